/* core/srb_bank.sv */
// register bank: buffered copy, active copy, commit on strobe or profile
`timescale 1ns/100ps
`default_nettype none
`include "srb_consts.svh"
module srb_bank #(
   parameter int NW = `SRB_NUM_WORDS
) (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire srb_pkg::srb_ser_req_type ser_req,
   output logic [31:0]                  ser_rdata,
   output logic                         ser_err,
   input  wire srb_pkg::srb_par_req_type par_req,
   output logic [7:0]                   par_rdata,
   input  wire logic                    io_update,
   input  wire logic [2:0]              profile_sel,
   input  wire logic                    pll_lock,
   output logic [NW*32-1:0]             active_regs,
   output logic                         cal_start
);
   // pins from outside pass two flops before use
   logic       upd_s1_ff, upd_s2_ff, upd_s3_ff;
   logic [2:0] ps_s1_ff, ps_s2_ff, ps_s3_ff;
   logic       lock_s1_ff, lock_s2_ff;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         upd_s1_ff  <= 1'b0;
         upd_s2_ff  <= 1'b0;
         upd_s3_ff  <= 1'b0;
         ps_s1_ff   <= 3'h0;
         ps_s2_ff   <= 3'h0;
         ps_s3_ff   <= 3'h0;
         lock_s1_ff <= 1'b0;
         lock_s2_ff <= 1'b0;
      end else begin
         upd_s1_ff  <= io_update;
         upd_s2_ff  <= upd_s1_ff;
         upd_s3_ff  <= upd_s2_ff;
         ps_s1_ff   <= profile_sel;
         ps_s2_ff   <= ps_s1_ff;
         ps_s3_ff   <= ps_s2_ff;
         lock_s1_ff <= pll_lock;
         lock_s2_ff <= lock_s1_ff;
      end
   end

   // profile compare is held off until the third stage has taken a real
   // pin value; a pin left non-zero through reset would fake a change, at
   // the cost that a pin value already present at the first sampling edge is never seen as a change
   logic [2:0] prime_ff, nxt_prime;
   logic       ps_change;
   always_comb begin
      nxt_prime = {prime_ff[1:0], 1'b1};
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) prime_ff <= 3'h0;
      else prime_ff <= nxt_prime;
   end
   assign ps_change = prime_ff[2] & (ps_s2_ff != ps_s3_ff);

   logic commit;
   // rising strobe or any profile change transfers the buffer
   assign commit = (upd_s2_ff & ~upd_s3_ff) | ps_change;

   // default of one serial word; only the user word has non-zero bytes
   function automatic logic [31:0] word_default(input int idx);
      if (idx == int'(`SRB_USR_ZERO_IDX))
         return {8'h00, `SRB_USR_TWO_RST, `SRB_USR_ONE_RST, 8'h00};
      return 32'h0;
   endfunction

   // parallel byte address split into word index and lane
   function automatic logic [4:0] byte_word(input logic [6:0] a);
      return a[6:2];
   endfunction

   logic [31:0] buf_ff [NW];
   logic [31:0] nxt_buf [NW];
   logic [31:0] act_ff [NW];
   logic [31:0] nxt_act [NW];
   logic        ser_hit;
   logic        par_hit;
   assign ser_hit = ser_req.addr <= `SRB_SER_LAST;
   assign par_hit = par_req.addr < 7'(`SRB_NUM_BYTES);

   // buffer takes host writes, active copy follows only on commit
   genvar gi;
   generate
      for (gi = 0; gi < NW; gi++) begin : g_word
         always_comb begin
            nxt_buf[gi] = buf_ff[gi];
            if (ser_req.wr && ser_hit && ser_req.addr == 5'(gi))
               nxt_buf[gi] = ser_req.wdata;
            if (par_req.wr && par_hit &&
                byte_word(par_req.addr) == 5'(gi))
               nxt_buf[gi][par_req.addr[1:0]*8 +: 8] = par_req.wdata;
            nxt_act[gi] = commit ? buf_ff[gi] : act_ff[gi];
         end
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               buf_ff[gi] <= word_default(gi);
               act_ff[gi] <= word_default(gi);
            end else begin
               buf_ff[gi] <= nxt_buf[gi];
               act_ff[gi] <= nxt_act[gi];
            end
         end
         assign active_regs[gi*32 +: 32] = act_ff[gi];
      end
   endgenerate

   // read data registered; lock byte reflects live lock state
   logic [31:0] ser_rdata_ff, nxt_ser_rdata;
   logic [7:0]  par_rdata_ff, nxt_par_rdata;
   logic        ser_err_ff, nxt_ser_err;
   logic [31:0] pword;
   always_comb begin
      nxt_ser_rdata = ser_rdata_ff;
      nxt_ser_err   = 1'b0;
      if (ser_req.rd) begin
         if (ser_hit) begin
            nxt_ser_rdata = buf_ff[ser_req.addr];
            if (ser_req.addr == `SRB_USR_ZERO_IDX)
               nxt_ser_rdata[31:24] = {7'h00, lock_s2_ff};
         end else begin
            nxt_ser_rdata = 32'h0;
            nxt_ser_err   = 1'b1;
         end
      end
      pword = par_hit ? buf_ff[byte_word(par_req.addr)] : 32'h0;
      nxt_par_rdata = pword[par_req.addr[1:0]*8 +: 8];
      if (par_req.addr == `SRB_USR_LOCK_BYTE)
         nxt_par_rdata = {7'h00, lock_s2_ff};
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ser_rdata_ff <= 32'h0;
         par_rdata_ff <= 8'h00;
         ser_err_ff   <= 1'b0;
      end else begin
         ser_rdata_ff <= nxt_ser_rdata;
         par_rdata_ff <= nxt_par_rdata;
         ser_err_ff   <= nxt_ser_err;
      end
   end
   assign ser_rdata = ser_rdata_ff;
   assign par_rdata = par_rdata_ff;
   assign ser_err   = ser_err_ff;

   // calibration starts on the active bit rising; clear needed to rearm
   srb_pkg::srb_state_type cal_st_ff, nxt_cal_st;
   logic cal_bit;
   // enable sits under the read-only lock byte, clear of the fixed bytes
   assign cal_bit = act_ff[`SRB_USR_ZERO_IDX][`SRB_CAL_BIT];
   always_comb begin
      case (cal_st_ff)
         srb_pkg::SRB_IDLE:
            nxt_cal_st = cal_bit ? srb_pkg::SRB_COMMIT : srb_pkg::SRB_IDLE;
         srb_pkg::SRB_COMMIT:
            nxt_cal_st = cal_bit ? srb_pkg::SRB_COMMIT : srb_pkg::SRB_IDLE;
         default: nxt_cal_st = srb_pkg::SRB_IDLE;
      endcase
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) cal_st_ff <= srb_pkg::SRB_IDLE;
      else cal_st_ff <= nxt_cal_st;
   end
   assign cal_start = cal_bit && cal_st_ff == srb_pkg::SRB_IDLE;

   // checks on commit, buffering, address range, calibration pulse width and reset default
   hold_no_commit_a: assert property (@(posedge clk) disable iff (reset)
      !commit |=> act_ff[0] == $past(act_ff[0]))
      else $error("active changed without commit");
   commit_copy_a: assert property (@(posedge clk) disable iff (reset)
      commit |=> act_ff[0] == $past(buf_ff[0]))
      else $error("commit did not copy buffer");
   profile_commit_a: assert property (@(posedge clk) disable iff (reset)
      ps_change |=> act_ff[1] == $past(buf_ff[1]))
      else $error("profile change did not commit");
   ser_range_a: assert property (@(posedge clk) disable iff (reset)
      ser_req.rd && ser_req.addr > `SRB_SER_LAST |=> ser_err)
      else $error("out of range serial read not flagged");
   ser_write_a: assert property (@(posedge clk) disable iff (reset)
      ser_req.wr && ser_req.addr == 5'h00 && !par_req.wr
      |=> buf_ff[0] == $past(ser_req.wdata))
      else $error("serial write to word zero lost");
   par_lane_a: assert property (@(posedge clk) disable iff (reset)
      par_req.wr && par_req.addr == 7'h01 && !ser_req.wr
      |=> buf_ff[0][15:8] == $past(par_req.wdata))
      else $error("parallel byte lane wrong");
   par_range_a: assert property (@(posedge clk) disable iff (reset)
      par_req.addr >= 7'h70 |=> par_rdata == 8'h00)
      else $error("unmapped parallel read not zero");
   cal_pulse_a: assert property (@(posedge clk) disable iff (reset)
      cal_start |=> !cal_start)
      else $error("calibration start longer than a cycle");
   reset_default_a: assert property (@(posedge clk)
      $fell(reset) |-> act_ff[`SRB_USR_ZERO_IDX][15:8] == 8'h08)
      else $error("user byte default wrong after reset");
   // checks on reads, refused writes and calibration
   ser_read_a: assert property (@(posedge clk) disable iff (reset)
      ser_req.rd && ser_req.addr == 5'h02
      |=> ser_rdata == $past(buf_ff[2]))
      else $error("serial read of word two wrong");
   lock_byte_a: assert property (@(posedge clk) disable iff (reset)
      par_req.addr == `SRB_USR_LOCK_BYTE
      |=> par_rdata == {7'h00, $past(lock_s2_ff)})
      else $error("lock byte read wrong");
   ser_refuse_a: assert property (@(posedge clk) disable iff (reset)
      ser_req.wr && ser_req.addr > `SRB_SER_LAST && !par_req.wr
      |=> buf_ff[`SRB_USR_ZERO_IDX] == $past(buf_ff[`SRB_USR_ZERO_IDX]))
      else $error("out of range serial write stored");
   par_refuse_a: assert property (@(posedge clk) disable iff (reset)
      par_req.wr && par_req.addr >= 7'h70 && !ser_req.wr
      |=> buf_ff[`SRB_USR_ZERO_IDX] == $past(buf_ff[`SRB_USR_ZERO_IDX]))
      else $error("out of range parallel write stored");
   cal_start_a: assert property (@(posedge clk) disable iff (reset)
      $rose(cal_bit) |-> cal_start)
      else $error("calibration did not start");
   cal_rearm_a: assert property (@(posedge clk) disable iff (reset)
      cal_bit && $past(cal_bit) |-> !cal_start)
      else $error("calibration restarted without clear");
   commit_c: cover property (@(posedge clk) disable iff (reset) commit);
   profile_c: cover property (@(posedge clk) disable iff (reset)
      ps_change);
   cal_c: cover property (@(posedge clk) disable iff (reset) cal_start);
   update_c: cover property (@(posedge clk) disable iff (reset)
      upd_s2_ff && !upd_s3_ff);
endmodule
`default_nettype wire

/* core/srb_consts.svh */
// constants for the synthesizer register bank with commit
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH
`define SRB_NUM_WORDS        28
`define SRB_NUM_BYTES        112
`define SRB_SER_LAST         5'h1B
`define SRB_CTRL_ONE_IDX     5'h00
`define SRB_USR_ZERO_IDX     5'h1B
`define SRB_USR_BYTE_ONE     7'h6D
`define SRB_USR_BYTE_TWO     7'h6E
`define SRB_USR_LOCK_BYTE    7'h6F
`define SRB_USR_ONE_RST      8'h08
`define SRB_USR_TWO_RST      8'h00
`define SRB_CAL_BIT          24
`define SRB_LOCK_BIT         24
`endif

/* core/srb_pkg.sv */
// types for the synthesizer register bank
package srb_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [31:0] wdata;
   } srb_ser_req_type;
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } srb_par_req_type;
   typedef enum logic [1:0] {
      SRB_IDLE   = 2'b01,
      SRB_COMMIT = 2'b10
   } srb_state_type;
endpackage

/* sim/srb_host.sv */
// host model: drives the bank's request pins and the io_update commit strobe
`timescale 1ns/100ps
`default_nettype none
module srb_host (
   input  wire logic                    clk,
   output var srb_pkg::srb_ser_req_type ser_req,
   output var srb_pkg::srb_par_req_type par_req,
   output var logic                     io_update
);
   initial begin
      ser_req = '0;
      par_req = '0;
      io_update = 1'b0;
   end
   // a request holds until the edge that samples it
   task automatic ser_op(input logic w, r, logic [4:0] a, logic [31:0] d);
      @(posedge clk) ser_req <= '{w, r, a, d};
      @(posedge clk) ser_req <= '0;
   endtask
   // address stays put since read data keeps following it
   task automatic par_op(input logic w, logic [6:0] a, logic [7:0] d);
      @(posedge clk) par_req <= '{w, a, d};
      @(posedge clk) par_req <= '{1'b0, a, 8'h00};
   endtask
   task automatic commit();
      @(posedge clk) io_update <= 1'b1;
      @(posedge clk) io_update <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// testbench: register bank behind the host model
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                     clk = 1'b0;
   logic                     reset = 1'b1, pll_lock = 1'b0;
   logic [2:0]               prof = 3'h0;
   logic                     up, serr, cal;
   logic [31:0]              srd;
   logic [7:0]               prd;
   logic [28*32-1:0]         act;
   srb_pkg::srb_ser_req_type sreq;
   srb_pkg::srb_par_req_type preq;
   int                       error_cnt = 0, check_count = 0;
   always #5 clk = ~clk; // 100 MHz
   srb_host u_host (.clk(clk), .ser_req(sreq), .par_req(preq), .io_update(up));
   srb_bank u_dut (.clk(clk), .reset(reset), .ser_req(sreq), .ser_rdata(srd),
      .ser_err(serr), .par_req(preq), .par_rdata(prd), .io_update(up),
      .profile_sel(prof), .pll_lock(pll_lock), .active_regs(act),
      .cal_start(cal));
   task automatic chk(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic par_chk(input logic [6:0] a, logic [7:0] e);
      u_host.par_op(1'b0, a, 8'h00);
      #1 chk({24'h0, prd}, {24'h0, e});
   endtask
   task automatic ser_chk(input logic [4:0] a, logic [31:0] e);
      u_host.ser_op(1'b0, 1'b1, a, 32'h0);
      #1 chk(srd, e);
   endtask
   // commit crosses a synchroniser, so poll under a bound
   task automatic wait_word(input int i, logic [31:0] e);
      #1;
      for (int n = 0; n < 10 && act[i*32+:32] !== e; n++) @(posedge clk) #1;
      chk(act[i*32+:32], e);
      if (act[i*32+:32] !== e) conclude();
   endtask
   task automatic t_commit();
      u_host.ser_op(1'b1, 1'b0, 5'h00, 32'h8000_0001);
      repeat (6) @(posedge clk);
      #1 chk(act[31:0], 32'h0000_0000);
      u_host.commit();
      wait_word(0, 32'h8000_0001);
      u_host.ser_op(1'b1, 1'b0, 5'h01, 32'h1234_5678);
      prof <= 3'h5;
      wait_word(1, 32'h1234_5678);
      $display("commit and profile done");
   endtask
   task automatic t_map();
      for (int b = 0; b < 4; b++)
         u_host.par_op(1'b1, 7'(8 + b), 8'(17 * b + 17));
      ser_chk(5'h02, 32'h4433_2211);
      u_host.par_op(1'b1, 7'h6C, 8'h5A);
      ser_chk(5'h1B, 32'h0100_085A);
      u_host.ser_op(1'b1, 1'b0, 5'h1D, 32'hFFFF_FFFF);
      ser_chk(5'h1B, 32'h0100_085A);
      u_host.ser_op(1'b0, 1'b1, 5'h1C, 32'h0);
      #1 chk({31'h0, serr}, 32'h0000_0001);
      u_host.par_op(1'b1, 7'h70, 8'hFF);
      par_chk(7'h70, 8'h00);
      par_chk(7'h6F, 8'h01);
      @(posedge clk) pll_lock <= 1'b0;
      repeat (3) @(posedge clk);
      par_chk(7'h6F, 8'h00);
      @(posedge clk) pll_lock <= 1'b1;
      repeat (3) @(posedge clk);
      $display("byte map and range done");
   endtask
   task automatic t_reset();
      @(posedge clk) reset <= 1'b1;
      @(posedge clk) reset <= 1'b0;
      #1 chk(act[27*32+:32], 32'h0000_0800);
      chk(act[31:0], 32'h0000_0000);
      ser_chk(5'h00, 32'h0000_0000);
      $display("mid-run reset done");
   endtask
   // count start pulses over a fixed window; the pulse is one cycle wide
   task automatic cal_cnt(input int e);
      int n;
      n = 0;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk) #1;
         if (cal === 1'b1) n++;
      end
      chk(32'(n), 32'(e));
   endtask
   // host keeps the fixed user bytes while toggling the enable
   task automatic t_cal();
      u_host.ser_op(1'b1, 1'b0, 5'h1B, 32'h0100_0800);
      u_host.commit();
      cal_cnt(1);
      u_host.ser_op(1'b1, 1'b0, 5'h1B, 32'h0100_0800);
      u_host.commit();
      cal_cnt(0);
      u_host.ser_op(1'b1, 1'b0, 5'h1B, 32'h0000_0800);
      u_host.commit();
      cal_cnt(0);
      u_host.ser_op(1'b1, 1'b0, 5'h1B, 32'h0100_0800);
      u_host.commit();
      cal_cnt(1);
      u_host.ser_op(1'b1, 1'b0, 5'h1B, 32'h0000_0800);
      u_host.commit();
      cal_cnt(0);
      $display("calibration sequence done");
   endtask
   // main sequence: release reset, run each scenario, then report
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      pll_lock <= 1'b1;
      t_commit();
      t_map();
      t_cal();
      t_reset();
      conclude();
   end
endmodule
`default_nettype wire
